// [common/partition_priority_pkg.sv]
// constants, field layout and access carrier for the partition priority register bank
// assumes one clock domain and a simple word-wide register port driven by the fabric
//
// Overview of operation
// - 16-bit selector indexes per-space configuration accesses
// - separate selector register for every security space
// - selector at 0x0100, root/realm only with extension
// - priority at 0x0400, root/realm only with extension
// - each space reaches only its priority settings
// - bits 31:16 hold downstream priority
// - bits 15:0 hold inner priority
// - unsupported priority field reads zero, ignores writes
// - only reported width implemented, low bits used
// - polarity flag reported for each field
// - priority register only with priority partitioning
// - instance field routes to chosen instance settings
// - without instances, single settings set per partition
// - priority register is one 32-bit word
// - selector bits 27:24 choose resource instance
// - selector bit 16 internal flag, else zero
// - flag mismatch records error, write ignored
package partition_priority_pkg;

    // ------------------------------------------------------------
    // register offsets within each frame
    // ------------------------------------------------------------
    localparam logic [11:0] partition_select_off = 12'h0100;
    localparam logic [11:0] partition_priority_off = 12'h0400;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int partition_selector_lsb = 0;
    localparam int partition_selector_w = 16;
    localparam int internal_flag_bit = 16;
    localparam int resource_instance_choice_lsb = 24;
    localparam int resource_instance_choice_w = 4;
    localparam int downstream_priority_lsb = 16;
    localparam int inner_priority_lsb = 0;
    localparam int priority_field_w = 16;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [31:0] select_reset = 32'h0000_0000;
    localparam logic [15:0] priority_reset = 16'h0000;

    // security spaces, one-hot frame choice
    typedef enum logic [3:0] {
        space_secure = 4'b0001,
        space_nonsecure = 4'b0010,
        space_root = 4'b0100,
        space_realm = 4'b1000
    } security_space_e;

    // one register access request
    typedef struct packed {
        logic valid;              // access strobe, one cycle
        logic write;              // 1 write, 0 read
        security_space_e space;   // frame the access arrived through
        logic [11:0] offset;      // byte offset within the frame
        logic [31:0] wdata;       // write data, whole word
    } reg_req_s;

    // answer to an access
    typedef struct packed {
        logic valid;              // answer strobe, one cycle
        logic [31:0] rdata;       // read data
    } reg_rsp_s;

endpackage : partition_priority_pkg

// [src/partition_priority_config.sv]
// partition selector and per-partition priority register bank, four security frames
// assumes the fabric delivers single-word accesses tagged with their security frame
`timescale 1ns/1ps
`default_nettype none

module partition_priority_config #(
    parameter int part_count = 16,                  // implemented partitions per space
    parameter int instance_count = 1,               // implemented resource instances
    parameter int downstream_prio_width = 16,       // implemented downstream bits
    parameter int inner_prio_width = 16,            // implemented inner bits
    parameter bit downstream_prio_supported = 1'b1,
    parameter bit inner_prio_supported = 1'b1,
    parameter bit downstream_zero_lowest = 1'b1,
    parameter bit inner_zero_lowest = 1'b1,
    parameter bit priority_partitioning_present = 1'b1,
    parameter bit instance_select_present = 1'b0,
    parameter bit id_narrowing_present = 1'b0,
    parameter bit realm_extension_feature = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire partition_priority_pkg::reg_req_s req,
    output partition_priority_pkg::reg_rsp_s rsp,
    input wire partition_priority_pkg::security_space_e lookup_space,
    input wire logic [15:0] lookup_partition,
    input wire logic [3:0] lookup_instance,
    output logic [15:0] lookup_downstream_priority,
    output logic [15:0] lookup_inner_priority,
    output logic downstream_zero_lowest_flag,
    output logic inner_zero_lowest_flag,
    output logic internal_mismatch_error
);

    // ------------------------------------------------------------
    // sizes and elaboration checks
    // ------------------------------------------------------------
    localparam int spaces = 4;
    localparam int entries = spaces * part_count * instance_count;
    localparam int pw = (part_count > 1) ? $clog2(part_count) : 1;
    localparam int iw = (instance_count > 1) ? $clog2(instance_count) : 1;
    localparam int ew = $clog2(entries);

    initial begin
        if (part_count < 1 || part_count > 65536)
            $error("part_count out of range");
        if (instance_count < 1 || instance_count > 16)
            $error("instance_count out of range");
        if (downstream_prio_width < 1 || downstream_prio_width > 16)
            $error("downstream_prio_width out of range");
        if (inner_prio_width < 1 || inner_prio_width > 16)
            $error("inner_prio_width out of range");
    end

    // implemented-bit masks for each field
    localparam logic [15:0] ds_mask = downstream_prio_supported ?
        16'((17'h1_0000 >> (16 - downstream_prio_width)) - 17'h0_0001) : 16'h0000;
    localparam logic [15:0] in_mask = inner_prio_supported ?
        16'((17'h1_0000 >> (16 - inner_prio_width)) - 17'h0_0001) : 16'h0000;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [31:0] select_reg [spaces];      // one selector per space
    logic [15:0] ds_mem [entries];         // downstream priority per entry
    logic [15:0] in_mem [entries];         // inner priority per entry
    logic error_reg;                       // sticky flag mismatch error
    partition_priority_pkg::reg_rsp_s rsp_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [1:0] space_idx;                 // frame of the current access
    logic frame_ok;                        // frame exists
    logic hit_sel;
    logic hit_pri;
    logic [31:0] cur_sel;                  // selector of the accessing space
    logic in_range;                        // selected entry is implemented
    logic flag_ok;                         // internal flag matches narrowing
    logic [ew-1:0] cur_idx;                // entry addressed by the access
    logic [31:0] sel_wmask;                // writable selector bits

    // map one-hot frame to index
    function automatic logic [1:0] space_index(partition_priority_pkg::security_space_e s);
        logic [1:0] r;
        r = 2'd0;
        case (s)
            partition_priority_pkg::space_nonsecure: r = 2'd1;
            partition_priority_pkg::space_root: r = 2'd2;
            partition_priority_pkg::space_realm: r = 2'd3;
            default: r = 2'd0;
        endcase
        return r;
    endfunction : space_index

    // flat entry index from space, instance and partition
    function automatic logic [ew-1:0] entry_of(logic [1:0] s, logic [3:0] ins, logic [15:0] p);
        int unsigned e;
        e = 0;
        e = (int'(s) * instance_count + (instance_select_present ? int'(ins) : 0))
            * part_count + int'(p);
        return ew'(e);
    endfunction : entry_of

    always_comb begin
        space_idx = space_index(req.space);
        frame_ok = realm_extension_feature || space_idx < 2'd2;
        hit_sel = frame_ok && req.offset == partition_priority_pkg::partition_select_off;
        hit_pri = frame_ok && priority_partitioning_present &&
            req.offset == partition_priority_pkg::partition_priority_off;
        cur_sel = select_reg[space_idx];
        in_range = int'(cur_sel[15:0]) < part_count &&
            (!instance_select_present || int'(cur_sel[27:24]) < instance_count);
        flag_ok = cur_sel[partition_priority_pkg::internal_flag_bit] == id_narrowing_present;
        cur_idx = entry_of(space_idx, cur_sel[27:24], cur_sel[15:0]);
        sel_wmask = 32'h0000_ffff;
        // internal flag writable only with narrowing
        if (id_narrowing_present) begin
            sel_wmask[partition_priority_pkg::internal_flag_bit] = 1'b1;
        end
        // instance field writable only with instances
        if (instance_select_present) begin
            sel_wmask = sel_wmask | 32'h0f00_0000;
        end
    end

    // ------------------------------------------------------------
    // selector registers
    // ------------------------------------------------------------
    // one selector per space
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int s = 0; s < spaces; s++) begin
                select_reg[s] <= partition_priority_pkg::select_reset;
            end
        end else if (req.valid && req.write && hit_sel) begin
            select_reg[space_idx] <= req.wdata & sel_wmask;
        end
    end

    // ------------------------------------------------------------
    // priority storage
    // ------------------------------------------------------------
    // one pair per entry
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int e = 0; e < entries; e++) begin
                ds_mem[e] <= partition_priority_pkg::priority_reset;
                in_mem[e] <= partition_priority_pkg::priority_reset;
            end
        end else if (req.valid && req.write && hit_pri && flag_ok && in_range) begin
            ds_mem[cur_idx] <= req.wdata[31:16] & ds_mask;
            in_mem[cur_idx] <= req.wdata[15:0] & in_mask;
        end
    end

    // ------------------------------------------------------------
    // error status
    // ------------------------------------------------------------
    // sticky mismatch record
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            error_reg <= 1'b0;
        end else if (req.valid && hit_pri && !flag_ok) begin
            error_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read answer, one cycle after the request
    // ------------------------------------------------------------
    // whole-word answer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= req.valid;
            rsp_reg.rdata <= 32'h0000_0000;
            if (req.valid && !req.write) begin
                if (hit_sel) begin
                    rsp_reg.rdata <= cur_sel;
                end else if (hit_pri && flag_ok && in_range) begin
                    rsp_reg.rdata <= {ds_mem[cur_idx], in_mem[cur_idx]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // traffic-side lookup and reported flags
    // ------------------------------------------------------------
    // lookup confined to its space
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lookup_downstream_priority <= 16'h0000;
            lookup_inner_priority <= 16'h0000;
        end else begin
            // instance and partition folded into range so a stray key never reads past the array
            lookup_downstream_priority <= ds_mem[entry_of(space_index(lookup_space),
                4'(int'(lookup_instance) % instance_count),
                16'(int'(lookup_partition) % part_count))];
            lookup_inner_priority <= in_mem[entry_of(space_index(lookup_space),
                4'(int'(lookup_instance) % instance_count),
                16'(int'(lookup_partition) % part_count))];
        end
    end

    assign rsp = rsp_reg;
    assign downstream_zero_lowest_flag = downstream_zero_lowest;
    assign inner_zero_lowest_flag = inner_zero_lowest;
    assign internal_mismatch_error = error_reg;

endmodule : partition_priority_config

`default_nettype wire

// [tb/partition_priority_props.sv]
// checker for the partition priority register bank, watching top-level ports only
// assumes one clock domain; bound onto every instance of the bank
`timescale 1ns/1ps
`default_nettype none

module partition_priority_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire partition_priority_pkg::reg_req_s req,
    input wire partition_priority_pkg::reg_rsp_s rsp,
    input wire partition_priority_pkg::security_space_e lookup_space,
    input wire logic [15:0] lookup_partition,
    input wire logic [3:0] lookup_instance,
    input wire logic [15:0] lookup_downstream_priority,
    input wire logic [15:0] lookup_inner_priority,
    input wire logic downstream_zero_lowest_flag,
    input wire logic inner_zero_lowest_flag,
    input wire logic internal_mismatch_error
);
    // ------------------------------------------------------------
    // access answers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_rsp_one_later: assert property (req.valid |=> rsp.valid)
        else $error("access got no answer one cycle later");
    a_no_stray_rsp: assert property (!req.valid |=> !rsp.valid)
        else $error("answer without an access");
    a_write_reads_zero: assert property (req.valid && req.write |=> rsp.rdata == 32'h0000_0000)
        else $error("write answer carried data");
    a_unmapped_zero: assert property (req.valid && req.offset != 12'h0100
        && req.offset != 12'h0400 |=> rsp.rdata == 32'h0000_0000)
        else $error("unmapped offset read nonzero");
    a_sel_reserved: assert property (req.valid && !req.write && req.offset == 12'h0100
        |=> rsp.rdata[31:28] == 4'h0 && rsp.rdata[23:17] == 7'h00)
        else $error("selector reserved bits read nonzero");
    // ------------------------------------------------------------
    // status and lookup
    // ------------------------------------------------------------
    a_error_sticky: assert property (internal_mismatch_error |=> internal_mismatch_error)
        else $error("mismatch error dropped without reset");
    a_flags_fixed: assert property ($stable(downstream_zero_lowest_flag)
        && $stable(inner_zero_lowest_flag))
        else $error("polarity flags changed");
    a_lookup_stable: assert property ($stable(lookup_space) && $stable(lookup_partition)
        && $stable(lookup_instance) && !$past(req.valid)
        |=> $stable(lookup_downstream_priority) && $stable(lookup_inner_priority))
        else $error("lookup priority moved with key and settings unchanged");
endmodule : partition_priority_props

bind partition_priority_config partition_priority_props u_props (.clk(clk), .arst_n(arst_n),
    .req(req), .rsp(rsp), .lookup_space(lookup_space), .lookup_partition(lookup_partition),
    .lookup_instance(lookup_instance), .lookup_downstream_priority(lookup_downstream_priority),
    .lookup_inner_priority(lookup_inner_priority),
    .downstream_zero_lowest_flag(downstream_zero_lowest_flag),
    .inner_zero_lowest_flag(inner_zero_lowest_flag),
    .internal_mismatch_error(internal_mismatch_error));

`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the partition priority register bank, inner field 12 bits wide
// assumes default parameters otherwise: 16 partitions, no instances, no narrowing
// a second copy with identifier narrowing covers the internal flag and its error
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    partition_priority_pkg::reg_req_s req = '0;
    partition_priority_pkg::reg_rsp_s rsp;
    partition_priority_pkg::security_space_e lk_space = partition_priority_pkg::space_secure;
    logic [15:0] lk_part = 16'h0000;
    logic [15:0] lk_ds;
    logic [15:0] lk_in;
    logic err_flag;           // mismatch error of the main copy
    logic ds_low;             // downstream polarity flag
    logic in_low;             // inner polarity flag
    logic err_nrw;            // mismatch error of the narrowing copy
    partition_priority_pkg::reg_req_s req_nrw = '0;
    partition_priority_pkg::reg_rsp_s rsp_nrw;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] sel_m [4];   // model selectors, one per space
    logic [31:0] pri_m [int]; // model priority words keyed by space and partition
    logic [11:0] offs [3] = '{12'h0100, 12'h0400, 12'h0220};

    // clock, 25 ns period
    always #12.5 clk = ~clk;

    partition_priority_config #(.inner_prio_width(12)) dut (.clk(clk), .arst_n(arst_n),
        .req(req), .rsp(rsp), .lookup_space(lk_space), .lookup_partition(lk_part),
        .lookup_instance(4'h0), .lookup_downstream_priority(lk_ds),
        .lookup_inner_priority(lk_in), .downstream_zero_lowest_flag(ds_low),
        .inner_zero_lowest_flag(in_low), .internal_mismatch_error(err_flag));

    // second copy with identifier narrowing, for the internal flag rules
    partition_priority_config #(.id_narrowing_present(1'b1)) dut_nrw (.clk(clk),
        .arst_n(arst_n), .req(req_nrw), .rsp(rsp_nrw), .lookup_space(lk_space),
        .lookup_partition(lk_part), .lookup_instance(4'h0),
        .lookup_downstream_priority(), .lookup_inner_priority(),
        .downstream_zero_lowest_flag(), .inner_zero_lowest_flag(),
        .internal_mismatch_error(err_nrw));

    // ------------------------------------------------------------
    // compare, access and lookup tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one access at the falling edge; the model predicts the answer
    task automatic acc(input int si, input logic wr, input logic [11:0] off,
        input logic [31:0] wd);
        logic [31:0] exp;
        int key;
        exp = 32'h0000_0000;
        key = (si << 16) + int'(sel_m[si][15:0]);
        if (off == 12'h0100) begin
            if (wr) sel_m[si] = {16'h0000, wd[15:0]};
            else exp = sel_m[si];
        end else if (off == 12'h0400 && sel_m[si][15:0] < 16'h0010) begin
            if (wr) pri_m[key] = wd & 32'hffff_0fff;
            else if (pri_m.exists(key)) exp = pri_m[key];
        end
        req.valid = 1'b1;
        req.write = wr;
        req.space = partition_priority_pkg::security_space_e'(4'b0001 << si);
        req.offset = off;
        req.wdata = wd;
        @(negedge clk);
        check({31'h0000_0000, rsp.valid}, 32'h0000_0001);
        check(rsp.rdata, exp);
    endtask : acc

    // one secure access to the narrowing copy; the caller gives the expected answer
    task automatic nacc(input logic wr, input logic [11:0] off, input logic [31:0] wd,
        input logic [31:0] exp);
        req_nrw.valid = 1'b1;
        req_nrw.write = wr;
        req_nrw.space = partition_priority_pkg::space_secure;
        req_nrw.offset = off;
        req_nrw.wdata = wd;
        @(negedge clk);
        check({31'h0000_0000, rsp_nrw.valid}, 32'h0000_0001);
        check(rsp_nrw.rdata, exp);
    endtask : nacc

    // traffic lookup of one partition, answered one cycle later
    task automatic look(input int si, input logic [15:0] p);
        logic [31:0] e;
        e = pri_m.exists((si << 16) + p) ? pri_m[(si << 16) + p] : 32'h0000_0000;
        req.valid = 1'b0;
        lk_space = partition_priority_pkg::security_space_e'(4'b0001 << si);
        lk_part = p;
        @(negedge clk);
        check({lk_ds, lk_in}, e);
    endtask : look

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h1630_dfae));
        for (int s = 0; s < 4; s++) sel_m[s] = 32'h0000_0000;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        // reset values in every frame
        for (int s = 0; s < 4; s++) begin
            acc(s, 1'b0, 12'h0100, 32'h0000_0000);
            acc(s, 1'b0, 12'h0400, 32'h0000_0000);
        end
        $display("test reset_values done");
        // same partition, four spaces, distinct words
        for (int s = 0; s < 4; s++) begin
            acc(s, 1'b1, 12'h0100, 32'h0f01_0005);
            acc(s, 1'b1, 12'h0400, 32'h1234_ffff + (s << 20));
        end
        for (int s = 0; s < 4; s++) begin
            acc(s, 1'b0, 12'h0400, 32'h0000_0000);
            look(s, 16'h0005);
        end
        $display("test space_isolation done");
        // reset in mid-run clears selectors and every stored pair
        arst_n = 1'b0;
        for (int s = 0; s < 4; s++) sel_m[s] = 32'h0000_0000;
        pri_m.delete();
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        for (int s = 0; s < 4; s++) begin
            acc(s, 1'b0, 12'h0100, 32'h0000_0000);
            look(s, 16'h0005);
        end
        $display("test mid_reset done");
        // back-to-back random traffic, out-of-range selectors included
        // internal flag left at 0 by the stimulus
        repeat (80) begin
            int s;
            int o;
            s = $urandom_range(3);
            o = $urandom_range(2);
            acc(s, 1'($urandom), offs[o],
                o == 0 ? ($urandom & 32'h0f00_0013) : $urandom);
        end
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 16; p++) look(s, 16'(p));
        end
        $display("test random_traffic done");
        // narrowing copy: priority access needs the internal flag set
        nacc(1'b1, 12'h0100, 32'h0000_0003, 32'h0000_0000);
        nacc(1'b1, 12'h0400, 32'h0005_0007, 32'h0000_0000);
        check({31'h0000_0000, err_nrw}, 32'h0000_0001);
        nacc(1'b1, 12'h0100, 32'h0001_0003, 32'h0000_0000);
        nacc(1'b0, 12'h0100, 32'h0000_0000, 32'h0001_0003);
        nacc(1'b0, 12'h0400, 32'h0000_0000, 32'h0000_0000);
        nacc(1'b1, 12'h0400, 32'h0005_0007, 32'h0000_0000);
        nacc(1'b0, 12'h0400, 32'h0000_0000, 32'h0005_0007);
        req_nrw.valid = 1'b0;
        check({31'h0000_0000, err_flag}, 32'h0000_0000);
        check({30'h0000_0000, ds_low, in_low}, 32'h0000_0003);
        $display("test narrowing done");
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
